// [rtl/fprl_consts.vh]
// constants for the fan drive ramp limiter: offsets, fields, resets, timing
`ifndef FPRL_CONSTS_VH
`define FPRL_CONSTS_VH

// register indices (printed offsets); byte address is four times the index
`define FPRL_IDX_DUTY_ONE 8'h30
`define FPRL_IDX_DUTY_TWO 8'h31
`define FPRL_IDX_DUTY_THREE 8'h32
`define FPRL_IDX_DRIVE_ONE_STEP_SELECT_FIRST 8'h62
`define FPRL_IDX_DRIVE_ONE_STEP_SELECT_SECOND 8'h63
`define FPRL_IDX_TARGET_ONE 8'h70
`define FPRL_IDX_TARGET_TWO 8'h71
`define FPRL_IDX_TARGET_THREE 8'h72

// field positions
`define FPRL_ONE_SEL_LSB 0
`define FPRL_ONE_EN_BIT 3
`define FPRL_TWO_SEL_LSB 4
`define FPRL_TWO_EN_BIT 7
`define FPRL_THREE_SEL_LSB 0
`define FPRL_THREE_EN_BIT 3

// reset values
`define FPRL_DUTY_RESET 8'hff
`define FPRL_DRIVE_ONE_STEP_SELECT_FIRST_RESET 8'h00
`define FPRL_DRIVE_ONE_STEP_SELECT_SECOND_RESET 8'h00

// timing: full 255-slot swing at one slot per update takes 35 s
`define FPRL_CLK_HZ 125000000
`define FPRL_SWING_MS 35000
`define FPRL_SLOTS 255
// 35 s / 255 updates = 137.25 ms, rounded down to whole cycles; the
// product 35000 * 125000 overflows a 32-bit constant, so it is spelt out
`define FPRL_UPDATE_CYCLES 17156862

`endif

// [rtl/fprl_ramp_limiter.v]
// fan drive ramp limiter: AXI4-Lite registers and three slew channels
// Overview of operation
// RL1 - drive one step from first register bits 2:0
// RL2 - codes map to 1,2,3,5,8,12,24,48 slots
// RL3 - one slot step sweeps full range in 35s
// RL4 - drive two step from second register bits 6:4
// RL5 - keep ramping up while target exceeds previous
// RL6 - three 8-bit duty registers, reset 0xff
// RL7 - limiting only when drive enable bit set
// RL8 - step previous value toward target, store it
// RL9 - duty period is 255 timeslots
// RL10 - drive three step from second register bits 2:0
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "fprl_consts.vh"
`default_nettype none
module fprl_ramp_limiter #(
   parameter UPDATE_CYCLES = `FPRL_UPDATE_CYCLES
) (
   input wire clk_sys,
   input wire rst_b,
   input wire [9:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [9:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [23:0] calc_target,
   output reg [2:0] fan_pwm
);
   ///////////////////////////////////////////////////////////////////////////
   // update pacing

   reg [31:0] tick_cnt_reg;
   wire tick;
   // one update per 137 ms so a 1-slot sweep of 255 slots takes 35 s
   assign tick = (tick_cnt_reg == UPDATE_CYCLES - 1); // [RL3]
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         tick_cnt_reg <= 32'h00000000;
      end else if (tick) begin
         tick_cnt_reg <= 32'h00000000;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write side: address and data held until both present

   reg [7:0] drive_one_step_select_first_reg;
   reg [7:0] drive_one_step_select_second_reg;
   reg aw_held_reg;
   reg w_held_reg;
   reg [7:0] aw_idx_reg;
   reg [7:0] wdata_reg;
   reg wstrb0_reg;
   wire wr_fire;
   wire [7:0] wr_idx;
   wire [2:0] duty_wr;

   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
   assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign wr_idx = aw_idx_reg;

   // capture each channel independently; respond once both are held
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_idx_reg <= 8'h00;
         wdata_reg <= 8'h00;
         wstrb0_reg <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_idx_reg <= s_axi_awaddr[9:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata[7:0];
            wstrb0_reg <= s_axi_wstrb[0];
         end
         if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // unmapped offsets answer with a slave error
            case (wr_idx)
               `FPRL_IDX_DUTY_ONE, `FPRL_IDX_DUTY_TWO,
               `FPRL_IDX_DUTY_THREE, `FPRL_IDX_DRIVE_ONE_STEP_SELECT_FIRST,
               `FPRL_IDX_DRIVE_ONE_STEP_SELECT_SECOND: s_axi_bresp <= 2'h0;
               default: s_axi_bresp <= 2'h2;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // configuration registers; only byte lane 0 carries data
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         drive_one_step_select_first_reg <= `FPRL_DRIVE_ONE_STEP_SELECT_FIRST_RESET;
         drive_one_step_select_second_reg <= `FPRL_DRIVE_ONE_STEP_SELECT_SECOND_RESET;
      end else if (wr_fire && wstrb0_reg) begin
         if (wr_idx == `FPRL_IDX_DRIVE_ONE_STEP_SELECT_FIRST) begin
            drive_one_step_select_first_reg <= wdata_reg;
         end
         if (wr_idx == `FPRL_IDX_DRIVE_ONE_STEP_SELECT_SECOND) begin
            drive_one_step_select_second_reg <= wdata_reg;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // the three slew channels

   wire [2:0] chan_en;
   wire [8:0] chan_sel;
   wire [23:0] duty_all;

   assign chan_en[0] = drive_one_step_select_first_reg[`FPRL_ONE_EN_BIT]; // [RL7]
   assign chan_en[1] = drive_one_step_select_second_reg[`FPRL_TWO_EN_BIT]; // [RL7]
   assign chan_en[2] = drive_one_step_select_second_reg[`FPRL_THREE_EN_BIT]; // [RL7]
   assign chan_sel[2:0] =
      drive_one_step_select_first_reg[`FPRL_ONE_SEL_LSB+2:`FPRL_ONE_SEL_LSB]; // [RL1]
   assign chan_sel[5:3] =
      drive_one_step_select_second_reg[`FPRL_TWO_SEL_LSB+2:`FPRL_TWO_SEL_LSB]; // [RL4]
   assign chan_sel[8:6] =
      drive_one_step_select_second_reg[`FPRL_THREE_SEL_LSB+2:`FPRL_THREE_SEL_LSB]; // [RL10]

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_chan
         assign duty_wr[gi] = wr_fire && wstrb0_reg &&
            (wr_idx == `FPRL_IDX_DUTY_ONE + gi);
         fprl_slew_step u_step (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .tick(tick),
            .enable(chan_en[gi]),
            .step_sel(chan_sel[3*gi+2:3*gi]),
            .target(calc_target[8*gi+7:8*gi]),
            .sw_wr(duty_wr[gi]),
            .sw_data(wdata_reg),
            .duty_reg(duty_all[8*gi+7:8*gi])
         );
      end
   endgenerate

   ///////////////////////////////////////////////////////////////////////////
   // pwm outputs: 255 timeslots per period

   reg [7:0] slot_reg;
   integer k;
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         slot_reg <= 8'h00;
         fan_pwm <= 3'h0;
      end else begin
         // slot counts 0..254 so duty 0xff is always high
         slot_reg <= (slot_reg == 8'hfe) ? 8'h00 : slot_reg + 8'h01; // [RL9]
         for (k = 0; k < 3; k = k + 1) begin
            fan_pwm[k] <= (slot_reg < duty_all[8*k+:8]); // [RL9]
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read side

   assign s_axi_arready = !s_axi_rvalid;
   wire [7:0] rd_idx;
   assign rd_idx = s_axi_araddr[9:2];

   // read data registered; reads carry no side effects
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'h0;
         case (rd_idx)
            `FPRL_IDX_DUTY_ONE: s_axi_rdata <= {24'h000000, duty_all[7:0]};
            `FPRL_IDX_DUTY_TWO: s_axi_rdata <= {24'h000000, duty_all[15:8]};
            `FPRL_IDX_DUTY_THREE:
               s_axi_rdata <= {24'h000000, duty_all[23:16]};
            `FPRL_IDX_DRIVE_ONE_STEP_SELECT_FIRST: s_axi_rdata <= {24'h000000, drive_one_step_select_first_reg};
            `FPRL_IDX_DRIVE_ONE_STEP_SELECT_SECOND:
               s_axi_rdata <= {24'h000000, drive_one_step_select_second_reg};
            `FPRL_IDX_TARGET_ONE:
               s_axi_rdata <= {24'h000000, calc_target[7:0]};
            `FPRL_IDX_TARGET_TWO:
               s_axi_rdata <= {24'h000000, calc_target[15:8]};
            `FPRL_IDX_TARGET_THREE:
               s_axi_rdata <= {24'h000000, calc_target[23:16]};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= 2'h2;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // fprl_ramp_limiter
`default_nettype wire

// [rtl/fprl_slew_step.v]
// one ramp-limited duty channel: step decode and increment/decrement
`timescale 1ns/1ns
`include "fprl_consts.vh"
`default_nettype none
module fprl_slew_step (
   input wire clk_sys,
   input wire rst_b,
   input wire tick,
   input wire enable,
   input wire [2:0] step_sel,
   input wire [7:0] target,
   input wire sw_wr,
   input wire [7:0] sw_data,
   output reg [7:0] duty_reg
);
   reg [7:0] step;
   reg [8:0] duty_next;
   reg [8:0] sum;

   // step size decode: 1,2,3,5,8,12,24,48 slots
   always @* begin // [RL2]
      case (step_sel)
         3'h0: step = 8'h01;
         3'h1: step = 8'h02;
         3'h2: step = 8'h03;
         3'h3: step = 8'h05;
         3'h4: step = 8'h08;
         3'h5: step = 8'h0c;
         3'h6: step = 8'h18;
         default: step = 8'h30;
      endcase
   end

   // move toward target, clamped so a big step never overshoots
   always @* begin
      sum = 9'h000;
      duty_next = {1'b0, duty_reg};
      if (!enable) begin
         duty_next = {1'b0, target}; // unlimited when ramping off
      end else if (target > duty_reg) begin // [RL5] [RL8]
         sum = {1'b0, duty_reg} + {1'b0, step};
         duty_next = (sum > {1'b0, target}) ? {1'b0, target} : sum;
      end else if (target < duty_reg) begin // [RL8]
         duty_next = (duty_reg - target < step) ? {1'b0, target} :
            {1'b0, duty_reg - step};
      end
   end

   // software write wins over the update so a written value is kept
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         duty_reg <= `FPRL_DUTY_RESET; // [RL6]
      end else if (sw_wr) begin
         duty_reg <= sw_data; // [RL6]
      end else if (tick) begin
         duty_reg <= duty_next[7:0]; // [RL8] [RL9]
      end
   end
endmodule // fprl_slew_step
`default_nettype wire

// [tb/fprl_fan_model.sv]
// fan side: measures each drive's high slots per period
`timescale 1ns/1ns
`default_nettype none
module fprl_fan_model (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [2:0] fan_pwm,
   output var logic [23:0] seen
);
   int n = 0;
   logic [7:0] acc [3] = '{8'h0, 8'h0, 8'h0};
   ////////////////////////////////////////////////////////////////////////
   // any 255 cycles in a row hold each slot once, so no phase lock needed
   always @(posedge clk_sys) begin
      n <= (!rst_b || n == 254) ? 0 : n + 1;
      for (int i = 0; i < 3; i++) begin
         // the closing sample goes to seen only, so a window is 255 slots
         acc[i] <= (n == 254) ? 8'h0 : acc[i] + 8'(fan_pwm[i]);
         if (n == 254) seen[i*8 +: 8] <= acc[i] + 8'(fan_pwm[i]);
      end
   end
endmodule // fprl_fan_model
`default_nettype wire

// [tb/fprl_ramp_limiter_asserts.sv]
// checker: register bus timing of the ramp limiter
`timescale 1ns/1ns
`default_nettype none
module fprl_chk #(
   parameter UPDATE_CYCLES = 20
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [9:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////
   // both halves taken at once: answer two edges later
   property p_bans;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##2 s_axi_bvalid;
   endproperty
   a_bans: assert property (p_bans) else $error("write answer late");
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("bresp moved");
   property p_bdrop;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_bdrop: assert property (p_bdrop) else $error("bvalid stuck");
   property p_awref;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_awref: assert property (p_awref) else $error("write not refused");
   property p_rans;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rans: assert property (p_rans) else $error("read answer late");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("rdata moved");
   property p_rdrop;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_rdrop: assert property (p_rdrop) else $error("rvalid stuck");
   // a hole in the map answers with an error and zero data
   property p_unm;
      s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == 8'h40
         |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
   endproperty
   a_unm: assert property (p_unm) else $error("hole read wrong");
endmodule // fprl_chk
bind fprl_ramp_limiter fprl_chk #(.UPDATE_CYCLES(UPDATE_CYCLES)) u_chk (
   .clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready));
`default_nettype wire

// [tb/fprl_ramp_limiter_tb.sv]
// self-checking bench for the fan drive ramp limiter
`timescale 1ns/1ns
`default_nettype none
module fprl_ramp_limiter_tb;
   logic clk_sys = 0;
   logic rst_b = 0;
   logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0, ta, tw;
   logic [9:0] awa = 0, ara = 0;
   logic [31:0] wd = 0;
   logic [23:0] tgt = 24'hffffff;
   logic [7:0] d;
   logic [1:0] rs;
   wire aw_rdy, w_rdy, ar_rdy, b_v, r_v;
   wire [1:0] b_rsp, r_rsp;
   wire [31:0] r_dat;
   wire [2:0] pwm;
   wire [23:0] seen;
   int bad_count = 0, checks = 0, m, t, k;
   int unsigned seed = 6286;
   int steps[8] = '{1, 2, 3, 5, 8, 12, 24, 48};
   // short update period keeps every ramp quick
   fprl_ramp_limiter #(.UPDATE_CYCLES(20)) uut (
      .clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(aw_rdy), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(w_rdy),
      .s_axi_bresp(b_rsp), .s_axi_bvalid(b_v), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(ar_rdy),
      .s_axi_rdata(r_dat), .s_axi_rresp(r_rsp), .s_axi_rvalid(r_v),
      .s_axi_rready(rr), .calc_target(tgt), .fan_pwm(pwm));
   fprl_fan_model fans (.clk_sys(clk_sys), .rst_b(rst_b), .fan_pwm(pwm),
      .seen(seen));
   always #4 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////////////
   // helpers: random source, reference step, compare, verdict
   function automatic int xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed & 255;
   endfunction
   function automatic int nx(int m, int t, int s);
      if (s < 0) return t;
      if (t > m) return (m + s > t) ? t : m + s;
      return (m - s < t) ? t : m - s;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic end_sim();
      $display("mismatches %0d of %0d checks", bad_count, checks);
      if (bad_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // bus master; ready sampled mid-cycle where it has settled
   task automatic wr(input logic [9:0] a, input logic [7:0] v);
      logic da, dw;
      da = 0;
      dw = 0;
      awa <= a;
      wd <= {24'h0, v};
      awv <= 1;
      wv <= 1;
      while (!(da && dw)) begin
         @(negedge clk_sys);
         ta = aw_rdy && !da;
         tw = w_rdy && !dw;
         @(posedge clk_sys);
         if (ta) awv <= 0;
         if (tw) wv <= 0;
         da |= ta;
         dw |= tw;
      end
      do @(negedge clk_sys); while (b_v !== 1);
      @(posedge clk_sys);
      br <= 1;
      @(negedge clk_sys);
      chk(b_rsp, a == 10'h100 ? 2 : 0);
      @(posedge clk_sys);
      br <= 0;
   endtask
   // rready comes late on purpose so the answer must hold
   task automatic rd(input logic [9:0] a);
      ara <= a;
      arv <= 1;
      do @(negedge clk_sys); while (ar_rdy !== 1);
      @(posedge clk_sys);
      arv <= 0;
      do @(negedge clk_sys); while (r_v !== 1);
      @(posedge clk_sys);
      rr <= 1;
      @(negedge clk_sys);
      d = r_dat[7:0];
      rs = r_rsp;
      @(posedge clk_sys);
      rr <= 0;
   endtask
   // code 8 means limiting off; reads follow the reference step by step
   task automatic ramp(int ch, int c);
      logic [7:0] v;
      logic [9:0] a;
      int s;
      int lw;
      logic nw;
      a = 10'hc0 + 10'(4 * ch);
      v = c < 8 ? 8'(8 + c) : 8'h0;
      if (ch == 1) v = {v[3:0], 4'h0};
      s = c < 8 ? steps[c] : -1;
      wr(ch ? 10'h18c : 10'h188, v);
      t = xs();
      m = xs();
      tgt[ch*8 +: 8] <= 8'(t);
      wr(a, 8'(m));
      lw = 0;
      for (k = 0; m != t; k++) begin
         rd(a);
         nw = (d !== 8'(m));
         if (nw) m = nx(m, t, s);
         chk(d, m);
         // lower target that is still above: climb must go on; done just
         // after an update so the next update already sees the new target
         if (nw && !lw && t > m + 2) begin
            lw = 1;
            t = t - 1 - (t - m) / 2;
            tgt[ch*8 +: 8] <= 8'(t);
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (3) @(posedge clk_sys);
      rst_b <= 1;
      for (int i = 0; i < 6; i++) begin
         rd(i < 3 ? 10'hc0 + 10'(4 * i) : i < 5 ? 10'h17c + 10'(4 * i)
            : 10'h100);
         chk({rs, d}, i < 3 ? 10'h0ff : i < 5 ? 10'h0 : 10'h200);
      end
      // target echo registers show the calculated duty inputs
      for (int i = 0; i < 3; i++) begin
         rd(10'h1c0 + 10'(4 * i));
         chk({rs, d}, {2'h0, tgt[i*8 +: 8]});
      end
      wr(10'h100, 8'h5a);
      for (int ch = 0; ch < 3; ch++)
         for (int c = 0; c < 9; c++)
            ramp(ch, c);
      wr(10'h188, 8'h0);
      wr(10'h18c, 8'h0);
      tgt <= {8'(xs()), 8'(xs()), 8'(xs())};
      repeat (600) @(posedge clk_sys);
      for (int i = 0; i < 3; i++)
         chk(seen[i*8 +: 8], tgt[i*8 +: 8]);
      end_sim();
   end
   // watchdog well past the expected run length
   initial begin
      #800000;
      bad_count++;
      end_sim();
   end
endmodule // fprl_ramp_limiter_tb
`default_nettype wire
